/* core/nfsr_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nfsr_regs.svh"
module nfsr_top
  import nfsr_pkg::*;
#(
  parameter int RST_BUSY_CYC = 16,
  parameter int BLK_W        = 11
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_cs_n_in,
  input  wire logic        spi_mosi_in,
  input  wire logic        wp_n_in,
  output var  logic        miso_out,
  output var  logic        miso_oe_n_out,
  input  wire logic        op_done_in,
  input  wire logic        op_fail_in,
  input  wire logic [1:0]  ecc_result_in,
  output var  logic        op_start_out,
  output var  logic [1:0]  op_kind_out,
  output var  logic [16:0] op_row_out,
  output var  logic        op_otp_out,
  output logic             ecc_enable_out,
  output logic             quad_enable_out,
  output logic [1:0]       drive_strength_out,
  output logic             busy_out
);
  if (RST_BUSY_CYC < 1 || RST_BUSY_CYC > 255)
    $error("RST_BUSY_CYC must lie in 1..255");
  if (BLK_W != 11)
    $error("BLK_W must be 11 for the protection decode");

  function automatic logic is_short(input logic [7:0] c);
    is_short = (c == `NFSR_CMD_LATCH_SET) || (c == `NFSR_CMD_LATCH_CLR)
            || (c == `NFSR_CMD_DEV_RST);
  endfunction : is_short

  function automatic logic is_row(input logic [7:0] c);
    is_row = (c == `NFSR_CMD_PAGE_RD) || (c == `NFSR_CMD_PROG_EXE)
          || (c == `NFSR_CMD_BLK_ERASE);
  endfunction : is_row

  // Size of the shielded range doubles with each level step from 1 to 7; level 0 shields nothing, or everything with complement set
  function automatic logic prot_hit(input logic [BLK_W-1:0] blk, input logic [2:0] lvl,
                                    input logic top, input logic cmp);
    logic [11:0] span;
    logic        in_rng;
    span   = `NFSR_BLK_COUNT >> (3'h7 - lvl);
    in_rng = top ? ({1'b0, blk} >= (`NFSR_BLK_COUNT - span)) : ({1'b0, blk} < span);
    if (lvl == 3'h0)
      in_rng = 1'b0;
    prot_hit = in_rng ^ cmp;
  endfunction : prot_hit

  function automatic logic [7:0] feat_sel(input logic [7:0] a, input logic [31:0] im);
    feat_sel = (a == `NFSR_ADDR_PROT) ? im[31:24]
             : (a == `NFSR_ADDR_CFG)  ? im[23:16]
             : (a == `NFSR_ADDR_STAT) ? im[15:8]
             : (a == `NFSR_ADDR_DRV)  ? im[7:0] : 8'h00;
  endfunction : feat_sel

  // Link domain: shifting is reset by the frame's own select so a stopped clock is harmless
  logic        lrst;
  logic [5:0]  bit_cnt;
  logic [23:0] sh;
  logic [7:0]  cmd_q;
  logic [7:0]  ev_cmd;
  logic [23:0] ev_arg;
  logic        ev_tgl;
  logic [7:0]  out_sh;
  logic [31:0] img;
  logic [7:0]  cur_byte;
  logic        fire;
  logic        rd_load;
  logic [7:0]  rd_byte;

  assign lrst     = rst_in | spi_cs_n_in;
  assign cur_byte = {sh[6:0], spi_mosi_in};
  assign fire     = ((bit_cnt == `NFSR_BIT_SHORT_END) && is_short(cur_byte))
                 || ((bit_cnt == `NFSR_BIT_FEAT_END) && (cmd_q == `NFSR_CMD_FEAT_WR))
                 || ((bit_cnt == `NFSR_BIT_ROW_END) && is_row(cmd_q));
  assign rd_load  = (bit_cnt == `NFSR_BIT_RD_START) && (cmd_q == `NFSR_CMD_FEAT_RD);
  assign rd_byte  = feat_sel(sh[7:0], img);

  always_ff @(posedge spi_sclk_in or posedge lrst)
  begin
    if (lrst)
    begin
      bit_cnt <= 6'h00;
      sh      <= 24'h000000;
      cmd_q   <= 8'h00;
    end
    else
    begin
      sh <= {sh[22:0], spi_mosi_in};
      if (bit_cnt != `NFSR_BIT_SAT)
        bit_cnt <= bit_cnt + 6'h01;
      if (bit_cnt == `NFSR_BIT_SHORT_END)
        cmd_q <= cur_byte;
    end
  end

  // Held words stay put until the next command, long after the system side reads them
  always_ff @(posedge spi_sclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ev_cmd <= 8'h00;
      ev_arg <= 24'h000000;
      ev_tgl <= 1'b0;
    end
    else if (fire)
    begin
      ev_cmd <= (bit_cnt == `NFSR_BIT_SHORT_END) ? cur_byte : cmd_q;
      ev_arg <= {sh[22:0], spi_mosi_in};
      ev_tgl <= ~ev_tgl;
    end
  end

  always_ff @(negedge spi_sclk_in or posedge lrst)
  begin
    if (lrst)
    begin
      out_sh        <= 8'h00;
      miso_out      <= 1'b0;
      miso_oe_n_out <= 1'b1;
    end
    else if (rd_load)
    begin
      out_sh        <= {rd_byte[6:0], 1'b0};
      miso_out      <= rd_byte[7];
      miso_oe_n_out <= 1'b0;
    end
    else if (!miso_oe_n_out)
    begin
      out_sh   <= {out_sh[6:0], 1'b0};
      miso_out <= out_sh[7];
    end
  end

  a_read_drive: assert property (
    @(negedge spi_sclk_in) disable iff (lrst)
    rd_load |=> !miso_oe_n_out && (miso_out == $past(rd_byte[7])))
    else $error("feature read did not drive the selected byte");

  // System domain
  logic [2:0]  sync_q;
  logic        cs_s;
  logic        wp_n_s;
  logic        ev_d;
  logic        ev_pulse;
  nfsr_state_t state;
  nfsr_state_t next_state;
  logic [7:0]  rst_cnt;
  logic        boot_req;
  logic [2:0]  lvl;
  logic        top_bot;
  logic        compl_bit;
  logic        pr_wdis;
  logic        otp_lock;
  logic        otp_en;
  logic        ecc_en;
  logic        quad_en;
  logic [1:0]  ecc_res;
  logic        p_fail;
  logic        e_fail;
  logic        write_enable_latch;
  logic [1:0]  drs;
  logic        die_sel;

  nfsr_sync #(.WIDTH(3)) u_sync (
    .clk_in (clk_sys_in),
    .rst_in (rst_in),
    .d_in   ({spi_cs_n_in, wp_n_in, ev_tgl}),
    .q_out  (sync_q)
  );

  assign cs_s     = sync_q[2];
  assign wp_n_s   = sync_q[1];
  assign ev_pulse = sync_q[0] ^ ev_d;

  logic        go;
  logic        is_fw;
  logic [7:0]  fw_addr;
  logic [7:0]  fw_data;
  logic        wr_prot;
  logic        wr_cfg;
  logic        wr_drv;
  logic        is_rst;
  logic        is_wen;
  logic        is_wdis;
  logic        is_read;
  logic        is_prog;
  logic        is_erase;
  logic        tgt_prot;
  logic        otp_bad;
  logic        prog_blk;
  logic        erase_blk;
  logic        start_op;
  logic        lock_set;
  logic        op_end;
  logic        rst_end;

  assign go        = ev_pulse && (!busy_out || ev_cmd == `NFSR_CMD_DEV_RST);
  assign is_fw     = go && (ev_cmd == `NFSR_CMD_FEAT_WR);
  assign fw_addr   = ev_arg[15:8];
  assign fw_data   = ev_arg[7:0];
  assign wr_prot   = is_fw && (fw_addr == `NFSR_ADDR_PROT) && !(pr_wdis && !wp_n_s);
  assign wr_cfg    = is_fw && (fw_addr == `NFSR_ADDR_CFG);
  assign wr_drv    = is_fw && (fw_addr == `NFSR_ADDR_DRV);
  assign is_rst    = go && (ev_cmd == `NFSR_CMD_DEV_RST);
  assign is_wen    = go && (ev_cmd == `NFSR_CMD_LATCH_SET);
  assign is_wdis   = go && (ev_cmd == `NFSR_CMD_LATCH_CLR);
  assign is_read   = go && (ev_cmd == `NFSR_CMD_PAGE_RD);
  assign is_prog   = go && (ev_cmd == `NFSR_CMD_PROG_EXE) && write_enable_latch;
  assign is_erase  = go && (ev_cmd == `NFSR_CMD_BLK_ERASE) && write_enable_latch;
  assign tgt_prot  = prot_hit(ev_arg[16:6], lvl, top_bot, compl_bit);
  assign otp_bad   = otp_lock || (ev_arg[5:0] >= `NFSR_OTP_PAGES);
  assign prog_blk  = is_prog && (otp_en ? otp_bad : tgt_prot);
  assign erase_blk = is_erase && (otp_en || tgt_prot);
  assign start_op  = is_read || (is_prog && !prog_blk) || (is_erase && !erase_blk);
  assign lock_set  = wr_cfg && fw_data[`NFSR_BIT_OTP_LOCK] && otp_en;
  assign op_end    = ((state == NFSR_OP) || (state == NFSR_BOOT)) && op_done_in;
  assign rst_end   = (state == NFSR_RST) && (rst_cnt == 8'(RST_BUSY_CYC - 1));

  always_comb
  begin
    next_state = state;
    unique case (state)
      NFSR_IDLE: if (is_rst) next_state = NFSR_RST;
                 else if (start_op) next_state = NFSR_OP;
      NFSR_BOOT,
      NFSR_OP:   if (is_rst) next_state = NFSR_RST;
                 else if (op_done_in) next_state = NFSR_IDLE;
      NFSR_RST:  if (rst_end) next_state = NFSR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state    <= NFSR_BOOT;
      busy_out <= 1'b1;
      boot_req <= 1'b1;
      rst_cnt  <= 8'h00;
      ev_d     <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      // Registered copy of the state decode keeps the pin glitch-free
      busy_out <= (next_state != NFSR_IDLE);
      boot_req <= 1'b0;
      rst_cnt  <= (state == NFSR_RST && !is_rst) ? rst_cnt + 8'h01 : 8'h00;
      ev_d     <= sync_q[0];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      op_start_out <= 1'b0;
      op_kind_out  <= NFSR_K_READ;
      op_row_out   <= 17'h00000;
      op_otp_out   <= 1'b0;
    end
    else
    begin
      op_start_out <= (start_op && !busy_out) || boot_req;
      if (start_op && !busy_out)
      begin
        op_kind_out <= is_read ? NFSR_K_READ : (is_prog ? NFSR_K_PROG : NFSR_K_ERASE);
        op_row_out  <= ev_arg[16:0];
        op_otp_out  <= otp_en;
      end
      else if (boot_req)
        op_kind_out <= NFSR_K_READ;
    end
  end

  // Feature values persist; only the bits named below react to the reset command
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lvl       <= `NFSR_RST_LEVEL;
      top_bot   <= 1'b0;
      compl_bit <= 1'b0;
      pr_wdis   <= 1'b0;
    end
    else if (wr_prot)
    begin
      lvl       <= fw_data[`NFSR_BIT_LVL_MSB:`NFSR_BIT_LVL_LSB];
      top_bot   <= fw_data[`NFSR_BIT_TOP_BOT];
      compl_bit <= fw_data[`NFSR_BIT_COMPL];
      pr_wdis   <= fw_data[`NFSR_BIT_PR_WDIS];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      otp_lock <= 1'b0;
      otp_en   <= 1'b0;
      ecc_en   <= 1'b1;
      quad_en  <= 1'b0;
      drs      <= `NFSR_RST_DRS;
      die_sel  <= 1'b0;
    end
    else
    begin
      if (lock_set)
        otp_lock <= 1'b1;
      if (is_rst)
        otp_en <= 1'b0;
      else if (wr_cfg)
        otp_en <= fw_data[`NFSR_BIT_OTP_EN];
      if (wr_cfg)
      begin
        ecc_en  <= fw_data[`NFSR_BIT_ECC_EN];
        quad_en <= fw_data[`NFSR_BIT_QUAD_EN];
      end
      if (wr_drv)
      begin
        drs     <= {fw_data[`NFSR_BIT_DRS_HI], fw_data[`NFSR_BIT_DRS_LO]};
        die_sel <= fw_data[`NFSR_BIT_DIE_SEL];
      end
    end
  end

  // Status flags: hardware set wins over a clear in the same cycle, except the correction result, which the reset command clears
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ecc_res <= 2'h0;
      p_fail  <= 1'b0;
      e_fail  <= 1'b0;
      write_enable_latch     <= 1'b0;
    end
    else
    begin
      if (op_end && op_kind_out == NFSR_K_READ && !is_rst)
        ecc_res <= ecc_result_in;
      else if (is_rst)
        ecc_res <= 2'h0;
      if ((op_end && op_fail_in && op_kind_out == NFSR_K_PROG) || prog_blk)
        p_fail <= 1'b1;
      else if (is_prog || is_erase || is_rst)
        p_fail <= 1'b0;
      if ((op_end && op_fail_in && op_kind_out == NFSR_K_ERASE) || erase_blk)
        e_fail <= 1'b1;
      else if (is_prog || is_erase || is_rst)
        e_fail <= 1'b0;
      if (is_wen)
        write_enable_latch <= 1'b1;
      else if (is_wdis || is_prog || is_erase || lock_set)
        write_enable_latch <= 1'b0;
    end
  end

  // Image only moves between frames, so the link reads a settled word
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      img <= 32'h00000000;
    else if (cs_s)
      img <= {pr_wdis, 1'b0, lvl, top_bot, compl_bit, 1'b0,
              otp_lock, otp_en, 1'b0, ecc_en, 3'h0, quad_en,
              2'h0, ecc_res, p_fail, e_fail, write_enable_latch, busy_out,
              drs, die_sel, 5'h00};
  end

  assign ecc_enable_out     = ecc_en;
  assign quad_enable_out    = quad_en;
  assign drive_strength_out = drs;

  a_latch_set: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (ev_pulse && !busy_out && ev_cmd == `NFSR_CMD_LATCH_SET) |=> write_enable_latch)
    else $error("latch-set command did not set the latch");

  a_latch_clear: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (ev_pulse && !busy_out && ev_cmd == `NFSR_CMD_LATCH_CLR) |=> !write_enable_latch)
    else $error("latch-clear command left the latch set");

  a_wp_refuse: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (is_fw && fw_addr == `NFSR_ADDR_PROT && pr_wdis && !wp_n_s)
      |=> $stable(lvl) && $stable(top_bot) && $stable(compl_bit))
    else $error("protection bits changed while write protected");

  a_lock_sticky: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    otp_lock |=> otp_lock ##1 otp_lock)
    else $error("one-time lock was released");

  a_busy_ignore: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (busy_out && ev_pulse && ev_cmd != `NFSR_CMD_DEV_RST)
      |=> $stable(write_enable_latch) && $stable(lvl) && $stable(drs))
    else $error("command obeyed while busy");

  a_fail_clear: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (op_start_out && op_kind_out != NFSR_K_READ) |-> !p_fail && !e_fail)
    else $error("fail flags not cleared at operation start");

  a_rst_cmd: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    is_rst |=> (ecc_res == 2'h0) && !otp_en && $stable(ecc_en) && busy_out)
    else $error("reset command handled wrongly");

  a_busy_done: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (state == NFSR_OP && op_done_in && !is_rst) |=> !busy_out)
    else $error("busy did not drop at completion");

  a_status_ro: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    (is_fw && fw_addr == `NFSR_ADDR_STAT) |=> $stable(write_enable_latch) && $stable(p_fail))
    else $error("status register took a feature write");
endmodule : nfsr_top
`default_nettype wire

/* core/nfsr_regs.svh */
// Function
// - Feature registers are reached only by feature read/write with one address byte.
// - Power-up: protect level bits are 1; top/bottom, complement, write-disable are 0.
// - Level, top/bottom and complement pick all, none or part of the array.
// - Write-disable set and write-protect pin low refuse protection register writes.
// - One-time area has 25 pages of 2112 bytes; bits only go 1 to 0.
// - Setting the one-time area lock blocks all further changes to that area.
// - Access enable routes commands to the one-time area; cleared by power-up and reset.
// - With correction enabled, check data is made on program and used on read.
// - Correction enable powers up as 1 and survives the reset command.
// - Correction result: 00 clean, 01 one bit fixed, 10/11 uncorrectable.
// - Reset command clears the correction result; meaningless when correction is off.
// - After power-on the correction result reflects block 0, page 0.
// - Fail flags set on internal failure or on a locked or protected target.
// - Fail flags clear when program or erase begins and on reset command.
// - Write enable latch is read-only by feature access; set by latch-set command.
// - Latch cleared at power-up and by disable, program, erase and one-time lock.
// - Busy flag is 1 during power-up, read, program, erase, lock and reset; here setting the one-time lock does not raise it.
// - While busy, only feature read, reset and identification read are obeyed.
// - Busy flag returns to 0 when the operation completes.
// - Drive field 00..11 means 100, 75, 50, 25 percent; defaults to 10.
// - Written values persist until power cycle or rewrite; reset leaves them alone, except access enable, which it clears.
// - Status register ignores feature writes; only latch-set command sets the latch.
`ifndef NFSR_REGS_SVH
`define NFSR_REGS_SVH
`define NFSR_ADDR_PROT     8'ha0
`define NFSR_ADDR_CFG      8'hb0
`define NFSR_ADDR_STAT     8'hc0
`define NFSR_ADDR_DRV      8'hd0
`define NFSR_CMD_FEAT_RD   8'h0f
`define NFSR_CMD_FEAT_WR   8'h1f
`define NFSR_CMD_LATCH_SET 8'h06
`define NFSR_CMD_LATCH_CLR 8'h04
`define NFSR_CMD_DEV_RST   8'hff
`define NFSR_CMD_PAGE_RD   8'h13
`define NFSR_CMD_PROG_EXE  8'h10
`define NFSR_CMD_BLK_ERASE 8'hd8
`define NFSR_BIT_PR_WDIS   7
`define NFSR_BIT_LVL_MSB   5
`define NFSR_BIT_LVL_LSB   3
`define NFSR_BIT_TOP_BOT   2
`define NFSR_BIT_COMPL     1
`define NFSR_BIT_OTP_LOCK  7
`define NFSR_BIT_OTP_EN    6
`define NFSR_BIT_ECC_EN    4
`define NFSR_BIT_QUAD_EN   0
`define NFSR_BIT_DRS_HI    7
`define NFSR_BIT_DRS_LO    6
`define NFSR_BIT_DIE_SEL   5
`define NFSR_RST_LEVEL     3'h7
`define NFSR_RST_DRS       2'h2
`define NFSR_OTP_PAGES     6'h19
`define NFSR_BLK_COUNT     12'h800
`define NFSR_BIT_RD_START  6'h10
`define NFSR_BIT_SHORT_END 6'h07
`define NFSR_BIT_FEAT_END  6'h17
`define NFSR_BIT_ROW_END   6'h1f
`define NFSR_BIT_SAT       6'h20
`endif

/* core/nfsr_pkg.sv */
package nfsr_pkg;
  typedef enum logic [1:0] {
    NFSR_IDLE = 2'b00,
    NFSR_BOOT = 2'b01,
    NFSR_OP   = 2'b10,
    NFSR_RST  = 2'b11
  } nfsr_state_t;
  typedef enum logic [1:0] {
    NFSR_K_READ  = 2'b00,
    NFSR_K_PROG  = 2'b01,
    NFSR_K_ERASE = 2'b10
  } nfsr_kind_t;
endpackage : nfsr_pkg

/* core/nfsr_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module nfsr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output var  logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta  <= '0;
      q_out <= '0;
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule : nfsr_sync
`default_nettype wire

/* tb/nfsr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module nfsr_host (
  output var  logic spi_sclk_out,
  output var  logic spi_cs_n_out,
  output var  logic spi_mosi_out,
  input  wire logic miso_in
);
  initial
  begin
    spi_sclk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_mosi_out = 1'b0;
  end

  // Mode 0, single line only: no four-line instruction is ever issued
  task automatic frame(input logic [31:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    spi_cs_n_out = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      spi_mosi_out = tx[nbits-1-i];
      #62.5 spi_sclk_out = 1'b1;
      if (i >= 16)
        rx = {rx[6:0], miso_in};
      #62.5 spi_sclk_out = 1'b0;
    end
    #62.5 spi_cs_n_out = 1'b1;
    // Released line flips so a stale bit cannot pass for a driven one
    spi_mosi_out = ~spi_mosi_out;
    #300;
  endtask : frame
endmodule : nfsr_host
`default_nettype wire

/* tb/nand_feature_status_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nfsr_regs.svh"
module nand_feature_status_regs_tb;
  import nfsr_pkg::*;
  localparam int RST_CYC = 4;
  logic        clk_sys_in, rst_in, sclk, cs_n, mosi, wp_n_in, miso, miso_oe_n;
  logic        op_done_in, op_fail_in, op_start_out, op_otp_out, last_otp;
  logic [1:0]  ecc_result_in, op_kind_out, drive_strength_out, last_kind;
  logic        ecc_enable_out, quad_enable_out, busy_out;
  logic [16:0] op_row_out, last_row, row;
  logic [7:0]  v;
  int          errors, check_count, starts, busy_cnt;

  nfsr_top #(.RST_BUSY_CYC(RST_CYC)) u_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
    .spi_mosi_in(mosi), .wp_n_in(wp_n_in), .miso_out(miso), .miso_oe_n_out(miso_oe_n),
    .op_done_in(op_done_in), .op_fail_in(op_fail_in), .ecc_result_in(ecc_result_in),
    .op_start_out(op_start_out), .op_kind_out(op_kind_out), .op_row_out(op_row_out),
    .op_otp_out(op_otp_out), .ecc_enable_out(ecc_enable_out),
    .quad_enable_out(quad_enable_out), .drive_strength_out(drive_strength_out),
    .busy_out(busy_out));

  nfsr_host u_host (.spi_sclk_out(sclk), .spi_cs_n_out(cs_n), .spi_mosi_out(mosi),
    .miso_in(miso));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // Array engine stand-in: answers every start three cycles later
  always @(posedge clk_sys_in)
  begin
    if (busy_out === 1'b1)
      busy_cnt <= busy_cnt + 1;
    if (op_start_out === 1'b1)
    begin
      starts <= starts + 1;
      last_kind <= op_kind_out;
      last_row <= op_row_out;
      last_otp <= op_otp_out;
      repeat (3) @(posedge clk_sys_in);
      #2 op_done_in = 1'b1;
      @(posedge clk_sys_in);
      #2 op_done_in = 1'b0;
    end
  end

  task automatic tally_and_finish;
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic send(input logic [31:0] tx, input int n);
    logic [7:0] r;
    u_host.frame(tx, n, r);
  endtask : send

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    send({8'h00, `NFSR_CMD_FEAT_WR, a, d}, 24);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] r;
    u_host.frame({8'h00, `NFSR_CMD_FEAT_RD, a, 8'h00}, 24, r);
    chk(nm, {9'h0, e}, {9'h0, r});
  endtask : rd

  // Bounded wait for the n-th engine start to finish
  task automatic wait_op(input int n);
    int k;
    k = 0;
    while (!(starts == n && busy_out === 1'b0) && k < 400)
    begin
      @(posedge clk_sys_in);
      k++;
    end
    if (k >= 400)
      errors++;
    #2;
  endtask : wait_op

  initial
  begin
    #1ms;
    errors++;
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(32'hb94f));
    {rst_in, wp_n_in, op_done_in, op_fail_in} = 4'b1100;
    ecc_result_in = 2'b01;
    {errors, check_count, starts, busy_cnt} = '0;
    repeat (5) @(posedge clk_sys_in);
    #2 rst_in = 1'b0;
    wait_op(1);
    chk("boot_kind", {15'h0, NFSR_K_READ}, {15'h0, last_kind});
    chk("boot_row", 17'h0, last_row);
    chk("boot_busy", 17'h1, {16'h0, busy_cnt > 0});
    rd(`NFSR_ADDR_STAT, 8'h10, "stat_boot");
    rd(`NFSR_ADDR_PROT, 8'h38, "prot_rst");
    rd(`NFSR_ADDR_CFG, 8'h10, "cfg_rst");
    rd(`NFSR_ADDR_DRV, 8'h80, "drv_rst");
    chk("ecc_en", 17'h1, {16'h0, ecc_enable_out});
    repeat (6)
    begin
      v = 8'($urandom);
      v[7] = 1'b0;
      wr(`NFSR_ADDR_PROT, v);
      rd(`NFSR_ADDR_PROT, v & 8'h3e, "prot_rw");
      v = 8'($urandom);
      v[5] = 1'b0;
      wr(`NFSR_ADDR_DRV, v);
      rd(`NFSR_ADDR_DRV, v & 8'hc0, "drv_rw");
      chk("drv_pin", {15'h0, v[7:6]}, {15'h0, drive_strength_out});
    end
    wr(`NFSR_ADDR_CFG, 8'h01);
    rd(`NFSR_ADDR_CFG, 8'h01, "cfg_quad");
    chk("quad_pin", 17'h1, {16'h0, quad_enable_out});
    chk("ecc_off", 17'h0, {16'h0, ecc_enable_out});
    wr(`NFSR_ADDR_CFG, 8'h10);
    wr(`NFSR_ADDR_STAT, 8'hff);
    rd(`NFSR_ADDR_STAT, 8'h10, "stat_ro");
    wr(`NFSR_ADDR_PROT, 8'h80);
    @(posedge clk_sys_in);
    #2 wp_n_in = 1'b0;
    wr(`NFSR_ADDR_PROT, 8'h38);
    rd(`NFSR_ADDR_PROT, 8'h80, "prot_lock");
    @(posedge clk_sys_in);
    #2 wp_n_in = 1'b1;
    wr(`NFSR_ADDR_PROT, 8'h38);
    rd(`NFSR_ADDR_PROT, 8'h38, "prot_unlock");
    send({24'h0, `NFSR_CMD_LATCH_SET}, 8);
    rd(`NFSR_ADDR_STAT, 8'h12, "latch_set");
    send({24'h0, `NFSR_CMD_LATCH_CLR}, 8);
    rd(`NFSR_ADDR_STAT, 8'h10, "latch_clr");
    row = 17'($urandom);
    send({24'h0, `NFSR_CMD_LATCH_SET}, 8);
    send({`NFSR_CMD_PROG_EXE, 7'h0, row}, 32);
    rd(`NFSR_ADDR_STAT, 8'h18, "prog_prot");
    chk("no_start", 17'h1, 17'(starts));
    wr(`NFSR_ADDR_PROT, 8'h00);
    op_fail_in = 1'b1;
    send({24'h0, `NFSR_CMD_LATCH_SET}, 8);
    busy_cnt = 0;
    send({`NFSR_CMD_PROG_EXE, 7'h0, row}, 32);
    wait_op(2);
    chk("prog_kind", {15'h0, NFSR_K_PROG}, {15'h0, last_kind});
    chk("prog_row", row, last_row);
    chk("prog_busy", 17'h1, {16'h0, busy_cnt > 0});
    rd(`NFSR_ADDR_STAT, 8'h18, "prog_fail");
    op_fail_in = 1'b0;
    send({24'h0, `NFSR_CMD_LATCH_SET}, 8);
    send({`NFSR_CMD_BLK_ERASE, 7'h0, row}, 32);
    wait_op(3);
    chk("erase_kind", {15'h0, NFSR_K_ERASE}, {15'h0, last_kind});
    rd(`NFSR_ADDR_STAT, 8'h10, "fail_clr");
    ecc_result_in = 2'b11;
    send({`NFSR_CMD_PAGE_RD, 7'h0, row}, 32);
    wait_op(4);
    rd(`NFSR_ADDR_STAT, 8'h30, "ecc_bad");
    wr(`NFSR_ADDR_PROT, 8'h14);
    wr(`NFSR_ADDR_CFG, 8'h50);
    busy_cnt = 0;
    send({24'h0, `NFSR_CMD_DEV_RST}, 8);
    wait_op(4);
    chk("rst_busy", 17'(RST_CYC), 17'(busy_cnt));
    rd(`NFSR_ADDR_STAT, 8'h00, "stat_cmd_rst");
    rd(`NFSR_ADDR_CFG, 8'h10, "cfg_cmd_rst");
    rd(`NFSR_ADDR_PROT, 8'h14, "prot_keep");
    chk("oe_idle", 17'h1, {16'h0, miso_oe_n});
    wr(`NFSR_ADDR_CFG, 8'h50);
    row = {row[16:6], 6'h05};
    send({`NFSR_CMD_PAGE_RD, 7'h0, row}, 32);
    wait_op(5);
    chk("otp_sel", 17'h1, {16'h0, last_otp});
    wr(`NFSR_ADDR_CFG, 8'hd0);
    rd(`NFSR_ADDR_CFG, 8'hd0, "otp_lock");
    send({24'h0, `NFSR_CMD_LATCH_SET}, 8);
    send({`NFSR_CMD_PROG_EXE, 7'h0, row}, 32);
    rd(`NFSR_ADDR_STAT, 8'h38, "otp_prog_blk");
    chk("otp_no_start", 17'h5, 17'(starts));
    wr(`NFSR_ADDR_CFG, 8'h50);
    rd(`NFSR_ADDR_CFG, 8'hd0, "otp_sticky");
    tally_and_finish();
  end
endmodule : nand_feature_status_regs_tb
`default_nettype wire
